// *** lcr_pkg.sv ***
// package: register map, field layout and reset values of the lane conditioning register bank
package lcr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] LCR_ADDR_B0_SWING_LEVEL = 8'h34;
  localparam logic [7:0] LCR_ADDR_B0_SWING_TYPE = 8'h35;
  localparam logic [7:0] LCR_ADDR_A1_IDLE_CTRL = 8'h39;
  localparam logic [7:0] LCR_ADDR_L1_EQ = 8'h3A;
  localparam logic [7:0] LCR_ADDR_A1_SWING_LEVEL = 8'h3B;
  localparam logic [7:0] LCR_ADDR_A1_SWING_TYPE = 8'h3C;
  localparam logic [7:0] LCR_ADDR_L1_IDLE_THRESH = 8'h3D;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] LCR_RST_SWING_LEVEL = 8'h03;
  localparam logic [7:0] LCR_RST_SWING_TYPE = 8'h03;
  localparam logic [7:0] LCR_RST_IDLE_CTRL = 8'h00;
  localparam logic [7:0] LCR_RST_EQ = 8'h20;
  localparam logic [7:0] LCR_RST_IDLE_THRESH = 8'h00;
  // ----------------------------------------
  // writable masks; reserved bits read zero
  // ----------------------------------------
  localparam logic [7:0] LCR_MASK_SWING_LEVEL = 8'h7F;
  localparam logic [7:0] LCR_MASK_SWING_TYPE = 8'hFF;
  localparam logic [7:0] LCR_MASK_IDLE_CTRL = 8'h30;
  localparam logic [7:0] LCR_MASK_EQ = 8'h3F;
  localparam logic [7:0] LCR_MASK_IDLE_THRESH = 8'h0F;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LCR_IDLE_AUTO_BIT = 5;
  localparam int LCR_IDLE_FORCE_BIT = 4;
  localparam int LCR_EQ_EN_BIT = 5;
  localparam int LCR_GAIN_HI = 4;
  localparam int LCR_GAIN_LO = 3;
  localparam int LCR_BOOST_HI = 2;
  localparam int LCR_BOOST_LO = 0;
  localparam int LCR_DEASSERT_HI = 3;
  localparam int LCR_DEASSERT_LO = 2;
  localparam int LCR_ASSERT_HI = 1;
  localparam int LCR_ASSERT_LO = 0;
  localparam logic [1:0] LCR_GAIN_STAGES = 2'h3;
  localparam logic [6:0] LCR_SWING_600MV = 7'h03;
  localparam logic [6:0] LCR_SWING_800MV = 7'h07;
  localparam logic [7:0] LCR_RD_UNMAPPED = 8'h00;
endpackage : lcr_pkg

// *** lcr_if.sv ***
// interface: raw equalizer and idle fields passed to the lane control module, decoded fields passed back from it
`timescale 1ns/1ns
interface lcr_if;
  logic [7:0] eq_raw;
  logic [7:0] idle_raw;
  logic idle_detect;
  logic eq_enable;
  logic eq_bypass;
  logic [1:0] gain_stage_field;
  logic [2:0] boost_field;
  logic [4:0] eq_level;
  logic output_muted;
  logic signal_detect_enable;
  modport bank (output eq_raw, output idle_raw, output idle_detect,
    input eq_enable, input eq_bypass, input gain_stage_field, input boost_field,
    input eq_level, input output_muted, input signal_detect_enable);
  modport lane (input eq_raw, input idle_raw, input idle_detect,
    output eq_enable, output eq_bypass, output gain_stage_field, output boost_field,
    output eq_level, output output_muted, output signal_detect_enable);
endinterface : lcr_if

// *** lcr_lane_ctrl.sv ***
// lane control: splits equalizer field and resolves idle mode for lane 1 port A
`timescale 1ns/1ns
module lcr_lane_ctrl
  import lcr_pkg::*;
(
  lcr_if.lane lif
);
  // ----------------------------------------
  // equalizer decode
  // ----------------------------------------
  // field split
  assign lif.eq_enable = lif.eq_raw[LCR_EQ_EN_BIT];
  assign lif.gain_stage_field = lif.eq_raw[LCR_GAIN_HI:LCR_GAIN_LO];
  assign lif.boost_field = lif.eq_raw[LCR_BOOST_HI:LCR_BOOST_LO];
  // enabled with zero gain and boost is bypass
  assign lif.eq_bypass = lif.eq_enable && (lif.gain_stage_field == 2'h0) && (lif.boost_field == 3'h0);
  // 24 levels: stage times eight plus boost; stage code 3 folds onto stage 2
  assign lif.eq_level = {(lif.gain_stage_field == LCR_GAIN_STAGES) ? 2'h2 : lif.gain_stage_field,
    lif.boost_field};
  // ----------------------------------------
  // idle mode
  // ----------------------------------------
  // auto bit picks detector or manual bit
  // manual mode: bit 4 mutes, else drive with detect off
  assign lif.output_muted = lif.idle_raw[LCR_IDLE_AUTO_BIT] ? lif.idle_detect
    : lif.idle_raw[LCR_IDLE_FORCE_BIT];
  assign lif.signal_detect_enable = lif.idle_raw[LCR_IDLE_AUTO_BIT];
endmodule : lcr_lane_ctrl

// *** lcr_regs.sv ***
// register bank for lane 0 port B and lane 1 port A/input conditioning controls
//
// Contract
// - idle bit 5 picks auto idle; when 0, bit 4 decides output state
// - manual mode: bit 4 low drives with detect off, high forces muted idle
// - first swing register: 7-bit level, resets 03 hex 600 mV, 07 hex 800 mV
// - equalizer field: bit 5 enable, bits 4:3 gain stage, bits 2:0 boost
// - equalizer register resets to 20 hex, treated as bypass
// - equalizer offers 24 levels, three stages of eight boosts; 3F hex highest
// - second swing register: full 8-bit type and level, resets 03 hex, read/write
// - idle threshold: bits 3:2 de-assert, bits 1:0 assert, default 00
`timescale 1ns/1ns
module lcr_regs
  import lcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic lane1_idle_detect,
  output logic [6:0] port_b_lane0_output_swing_level,
  output logic [7:0] port_b_lane0_output_swing_type_level,
  output logic [6:0] port_a_lane1_output_swing_level,
  output logic [7:0] port_a_lane1_output_swing_type_level,
  output logic port_a_lane1_output_muted,
  output logic port_a_lane1_signal_detect_enable,
  output logic lane1_input_eq_enable,
  output logic lane1_input_eq_bypass,
  output logic [1:0] lane1_input_gain_stage_field,
  output logic [2:0] lane1_input_boost_field,
  output logic [4:0] lane1_input_eq_level,
  output logic [1:0] lane1_input_deassert_thresh,
  output logic [1:0] lane1_input_assert_thresh
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] b0_swing_level;
    logic [7:0] b0_swing_type;
    logic [7:0] a1_idle_ctrl;
    logic [7:0] l1_eq;
    logic [7:0] a1_swing_level;
    logic [7:0] a1_swing_type;
    logic [7:0] l1_idle_thresh;
    logic [7:0] rd_data;
  } lcr_state_t;

  lcr_state_t state_reg;
  lcr_state_t state_next;

  localparam lcr_state_t LCR_STATE_RST = '{
    b0_swing_level: LCR_RST_SWING_LEVEL,
    b0_swing_type: LCR_RST_SWING_TYPE,
    a1_idle_ctrl: LCR_RST_IDLE_CTRL,
    l1_eq: LCR_RST_EQ,
    a1_swing_level: LCR_RST_SWING_LEVEL,
    a1_swing_type: LCR_RST_SWING_TYPE,
    l1_idle_thresh: LCR_RST_IDLE_THRESH,
    rd_data: LCR_RD_UNMAPPED
  };

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [7:0] lcr_read(input lcr_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = LCR_RD_UNMAPPED;
    case (a)
      LCR_ADDR_B0_SWING_LEVEL: v = s.b0_swing_level;
      LCR_ADDR_B0_SWING_TYPE: v = s.b0_swing_type;
      LCR_ADDR_A1_IDLE_CTRL: v = s.a1_idle_ctrl;
      LCR_ADDR_L1_EQ: v = s.l1_eq;
      LCR_ADDR_A1_SWING_LEVEL: v = s.a1_swing_level;
      LCR_ADDR_A1_SWING_TYPE: v = s.a1_swing_type;
      LCR_ADDR_L1_IDLE_THRESH: v = s.l1_idle_thresh;
      default: v = LCR_RD_UNMAPPED;
    endcase
    return v;
  endfunction : lcr_read

  // decode of the seven places; anything else must read as zero
  function automatic logic lcr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      LCR_ADDR_B0_SWING_LEVEL, LCR_ADDR_B0_SWING_TYPE: hit = 1'b1;
      LCR_ADDR_A1_IDLE_CTRL, LCR_ADDR_L1_EQ: hit = 1'b1;
      LCR_ADDR_A1_SWING_LEVEL, LCR_ADDR_A1_SWING_TYPE: hit = 1'b1;
      LCR_ADDR_L1_IDLE_THRESH: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : lcr_mapped

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      case (addr)
        LCR_ADDR_B0_SWING_LEVEL: state_next.b0_swing_level = wr_data & LCR_MASK_SWING_LEVEL;
        LCR_ADDR_B0_SWING_TYPE: state_next.b0_swing_type = wr_data & LCR_MASK_SWING_TYPE;
        LCR_ADDR_A1_IDLE_CTRL: state_next.a1_idle_ctrl = wr_data & LCR_MASK_IDLE_CTRL;
        LCR_ADDR_L1_EQ: state_next.l1_eq = wr_data & LCR_MASK_EQ;
        LCR_ADDR_A1_SWING_LEVEL: state_next.a1_swing_level = wr_data & LCR_MASK_SWING_LEVEL;
        LCR_ADDR_A1_SWING_TYPE: state_next.a1_swing_type = wr_data & LCR_MASK_SWING_TYPE;
        LCR_ADDR_L1_IDLE_THRESH: state_next.l1_idle_thresh = wr_data & LCR_MASK_IDLE_THRESH;
        default: state_next = state_reg;
      endcase
    end
    // read data holds until the next read; unmapped reads give zero
    if (rd_en) begin
      state_next.rd_data = lcr_read(state_reg, addr);
    end
  end

  // swing registers reset to 03 hex
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= LCR_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // lane controls
  // ----------------------------------------
  lcr_if lif ();
  assign lif.eq_raw = state_reg.l1_eq;
  assign lif.idle_raw = state_reg.a1_idle_ctrl;
  assign lif.idle_detect = lane1_idle_detect;

  lcr_lane_ctrl u_lane (
    .lif(lif.lane)
  );

  // stored swing and threshold values drive analog controls directly; idle and equalizer outputs come from lane control
  assign rd_data = state_reg.rd_data;
  assign port_b_lane0_output_swing_level = state_reg.b0_swing_level[6:0];
  assign port_b_lane0_output_swing_type_level = state_reg.b0_swing_type;
  assign port_a_lane1_output_swing_level = state_reg.a1_swing_level[6:0];
  assign port_a_lane1_output_swing_type_level = state_reg.a1_swing_type;
  assign port_a_lane1_output_muted = lif.output_muted;
  assign port_a_lane1_signal_detect_enable = lif.signal_detect_enable;
  assign lane1_input_eq_enable = lif.eq_enable;
  assign lane1_input_eq_bypass = lif.eq_bypass;
  assign lane1_input_gain_stage_field = lif.gain_stage_field;
  assign lane1_input_boost_field = lif.boost_field;
  assign lane1_input_eq_level = lif.eq_level;
  assign lane1_input_deassert_thresh = state_reg.l1_idle_thresh[LCR_DEASSERT_HI:LCR_DEASSERT_LO];
  assign lane1_input_assert_thresh = state_reg.l1_idle_thresh[LCR_ASSERT_HI:LCR_ASSERT_LO];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // three gain stages of eight boost settings
  localparam logic [4:0] LCR_EQ_LEVELS = 5'h18;

  sequence s_wr_eq;
    wr_en && addr == LCR_ADDR_L1_EQ;
  endsequence

  sequence s_wr_b0_type;
    wr_en && addr == LCR_ADDR_B0_SWING_TYPE;
  endsequence

  sequence s_rd_b0_type;
    rd_en && addr == LCR_ADDR_B0_SWING_TYPE && !wr_en;
  endsequence

  a_idle_auto_mute: assert property (
    state_reg.a1_idle_ctrl[LCR_IDLE_AUTO_BIT] |-> port_a_lane1_output_muted == lane1_idle_detect)
    else $error("auto idle mute does not follow detector");
  a_idle_manual_force: assert property (
    !state_reg.a1_idle_ctrl[LCR_IDLE_AUTO_BIT] |->
      port_a_lane1_output_muted == state_reg.a1_idle_ctrl[LCR_IDLE_FORCE_BIT] && !port_a_lane1_signal_detect_enable)
    else $error("manual idle state wrong");
  a_swing_level_wr: assert property (
    wr_en && addr == LCR_ADDR_A1_SWING_LEVEL |=> port_a_lane1_output_swing_level == $past(wr_data[6:0]))
    else $error("swing level write not applied");
  a_eq_fields: assert property (
    s_wr_eq |=> lane1_input_gain_stage_field == $past(wr_data[4:3]) && lane1_input_boost_field == $past(wr_data[2:0])
      && lane1_input_eq_enable == $past(wr_data[5]))
    else $error("equalizer fields split wrong");
  a_eq_bypass: assert property (
    state_reg.l1_eq == LCR_RST_EQ |-> lane1_input_eq_bypass)
    else $error("equalizer default not bypass");
  a_eq_level_range: assert property (
    lane1_input_eq_level < LCR_EQ_LEVELS)
    else $error("equalizer level beyond 24");
  a_swing_type_wr: assert property (
    s_wr_b0_type ##1 s_rd_b0_type |=> rd_data == $past(wr_data, 2))
    else $error("swing type readback mismatch");
  a_thresh_wr: assert property (
    wr_en && addr == LCR_ADDR_L1_IDLE_THRESH |=>
      {lane1_input_deassert_thresh, lane1_input_assert_thresh} == $past(wr_data[3:0]))
    else $error("threshold write not applied");
  a_eq_readback: assert property (
    s_wr_eq ##1 (rd_en && addr == LCR_ADDR_L1_EQ && !wr_en) |=> rd_data == ($past(wr_data, 2) & LCR_MASK_EQ))
    else $error("equalizer readback mismatch");
  a_b0_level_wr: assert property (
    wr_en && addr == LCR_ADDR_B0_SWING_LEVEL |=> port_b_lane0_output_swing_level == $past(wr_data[6:0]))
    else $error("lane 0 swing level write not applied");
  a_b0_type_wr: assert property (
    s_wr_b0_type |=> port_b_lane0_output_swing_type_level == $past(wr_data))
    else $error("lane 0 swing type write not applied");
  a_a1_type_wr: assert property (
    wr_en && addr == LCR_ADDR_A1_SWING_TYPE |=> port_a_lane1_output_swing_type_level == $past(wr_data))
    else $error("lane 1 swing type write not applied");
  a_rd_unmapped: assert property (
    rd_en && !lcr_mapped(addr) |=> rd_data == LCR_RD_UNMAPPED)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_reserved_clear: assert property (
    (state_reg.b0_swing_level & ~LCR_MASK_SWING_LEVEL) == 8'h00
      && (state_reg.a1_swing_level & ~LCR_MASK_SWING_LEVEL) == 8'h00
      && (state_reg.l1_eq & ~LCR_MASK_EQ) == 8'h00
      && (state_reg.a1_idle_ctrl & ~LCR_MASK_IDLE_CTRL) == 8'h00
      && (state_reg.l1_idle_thresh & ~LCR_MASK_IDLE_THRESH) == 8'h00)
    else $error("reserved register bits set");
endmodule : lcr_regs

// *** test_lane_conditioning_config_regs.sv ***
// testbench: register access and lane control outputs of the conditioning register bank
`timescale 1ns/1ns
module test_lane_conditioning_config_regs import lcr_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic lane1_idle_detect = 1'b0;
  logic [7:0] rd_data, port_b_lane0_output_swing_type_level, port_a_lane1_output_swing_type_level, v;
  logic [6:0] port_b_lane0_output_swing_level, port_a_lane1_output_swing_level;
  logic port_a_lane1_output_muted, port_a_lane1_signal_detect_enable;
  logic lane1_input_eq_enable, lane1_input_eq_bypass;
  logic [1:0] lane1_input_gain_stage_field, lane1_input_deassert_thresh, lane1_input_assert_thresh;
  logic [2:0] lane1_input_boost_field;
  logic [4:0] lane1_input_eq_level;
  logic [7:0] al[7] = '{8'h34, 8'h35, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
  logic [7:0] rv[7] = '{8'h03, 8'h03, 8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
  logic [7:0] mk[7] = '{8'h7F, 8'hFF, 8'h30, 8'h3F, 8'h7F, 8'hFF, 8'h0F};
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;

  lcr_regs uut (.clk, .reset_n, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .lane1_idle_detect,
    .port_b_lane0_output_swing_level, .port_b_lane0_output_swing_type_level,
    .port_a_lane1_output_swing_level, .port_a_lane1_output_swing_type_level,
    .port_a_lane1_output_muted, .port_a_lane1_signal_detect_enable, .lane1_input_eq_enable,
    .lane1_input_eq_bypass, .lane1_input_gain_stage_field, .lane1_input_boost_field,
    .lane1_input_eq_level, .lane1_input_deassert_thresh, .lane1_input_assert_thresh);

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #4 clk = ~clk;

  // ceiling far above the roughly 64 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // strobes move at the falling edge so the rising edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
  endtask : rd

  // write then read of one place on the next edge; the read sees the new value
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    q = rd_data;
  endtask : wr_rd

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk({1'b0, port_a_lane1_output_swing_level}, 8'h03);
    chk({7'h00, lane1_input_eq_bypass}, 8'h01);
    chk({7'h00, lane1_input_eq_enable}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      rd(al[i], v);
      chk(v, rv[i]);
    end
    // reserved bits must come back as zero
    for (int i = 0; i < 7; i++) begin
      wr_rd(al[i], 8'hFF, v);
      chk(v, mk[i]);
    end
    chk(port_b_lane0_output_swing_type_level, 8'hFF);
    chk({1'b0, port_a_lane1_output_swing_level}, 8'h7F);
    wr(8'h34, 8'h07);
    chk({1'b0, port_b_lane0_output_swing_level}, 8'h07);
    wr(8'h3C, 8'hA5);
    chk(port_a_lane1_output_swing_type_level, 8'hA5);
    wr(8'h3A, 8'h2A);
    chk({7'h00, lane1_input_eq_enable}, 8'h01);
    chk({6'h00, lane1_input_gain_stage_field}, 8'h01);
    chk({5'h00, lane1_input_boost_field}, 8'h02);
    chk({3'h0, lane1_input_eq_level}, 8'h0A);
    chk({7'h00, lane1_input_eq_bypass}, 8'h00);
    wr(8'h3A, 8'h3F);
    chk({3'h0, lane1_input_eq_level}, 8'h17);
    wr(8'h3D, 8'h0E);
    chk({6'h00, lane1_input_deassert_thresh}, 8'h03);
    chk({6'h00, lane1_input_assert_thresh}, 8'h02);
    // manual mode ignores the detector
    lane1_idle_detect = 1'b1;
    wr(8'h39, 8'h00);
    chk({7'h00, port_a_lane1_output_muted}, 8'h00);
    chk({7'h00, port_a_lane1_signal_detect_enable}, 8'h00);
    wr(8'h39, 8'h10);
    chk({7'h00, port_a_lane1_output_muted}, 8'h01);
    wr(8'h39, 8'h20);
    chk({7'h00, port_a_lane1_output_muted}, 8'h01);
    chk({7'h00, port_a_lane1_signal_detect_enable}, 8'h01);
    lane1_idle_detect = 1'b0;
    #1;
    chk({7'h00, port_a_lane1_output_muted}, 8'h00);
    // unmapped place: write dropped, read zero
    wr(8'h36, 8'h5A);
    rd(8'h36, v);
    chk(v, 8'h00);
    rd(8'h3C, v);
    chk(v, 8'hA5);
    // mid-run reset puts the defaults back at once
    @(negedge clk);
    reset_n = 1'b0;
    #1;
    chk(port_a_lane1_output_swing_type_level, 8'h03);
    @(negedge clk);
    reset_n = 1'b1;
    rd(8'h3A, v);
    chk(v, 8'h20);
    conclude();
  end
endmodule : test_lane_conditioning_config_regs
